/* logic/mbd_map.vh */
// Field map and constants for the macroblock descriptor decoder
//
// Operation
// - Cr pattern in bits 23:20, bit 3-X
// - Cb pattern in bits 19:16, bit 3-X
// - Zero pattern bit forces block absent
// - Small transform or 16x16 intra: 16-bit luma
// - Large transform, not 16x16 intra: low four luma bits only
// - 4:2:2 Cb low byte; 4:4:4 per block
// - Direct mask honoured only for B inter
// - Clamp enable bit 27 gates clamping
// - Bit 26 marks last block in slice
// - Skip conversion off by bit OR slice
// - Chroma quantizer bytes ignored, derived downstream
// - Luma quantizer bits 7:0, range 0-51
// - Hard budget exceeded enters panic mode
// - Soft budget limits non-zero coefficients
// - Trellis lambda is field doubled
// - Upper nibble all ones bypasses trellis
// - Low nibble selects rounding offset
// - First intra mode word; 16x16 low bits
// - One more intra mode word, four modes
// - Word nine byte: availability and chroma mode
// - Words seven to nine intra or inter
// - Bit 13 selects intra block
// - Bit 15 selects large transform
`ifndef MBD_MAP_VH
`define MBD_MAP_VH

// Descriptor word indices
`define MBD_W_MODE        4'h3
`define MBD_W_CHROMA      4'h5
`define MBD_W_CTRL        4'h6
`define MBD_W_INTRA0      4'h7
`define MBD_W_INTRA1      4'h8
`define MBD_W_INTRA2      4'h9
`define MBD_W_BUDGET      4'ha
`define MBD_WORDS         4'hb
`define MBD_W_LAST        4'ha

// Word three bits
`define MBD_TX8_BIT       15
`define MBD_INTRA_BIT     13
`define MBD_MBTYPE_HI     12
`define MBD_MBTYPE_LO     8

// Word five fields
`define MBD_CR_HI         23
`define MBD_CR_LO         20
`define MBD_CB_HI         19
`define MBD_CB_LO         16
`define MBD_CB16_HI       31
`define MBD_CB16_LO       16

// Word six fields
`define MBD_DIRECT_HI     31
`define MBD_DIRECT_LO     28
`define MBD_CLAMP_BIT     27
`define MBD_LASTMB_BIT    26
`define MBD_SKIPOFF_BIT   25
`define MBD_QP_HI         7
`define MBD_QP_LO         0
`define MBD_QP_MAX        8'h33

// Word ten fields
`define MBD_HARD_HI       31
`define MBD_HARD_LO       24
`define MBD_SOFT_HI       23
`define MBD_SOFT_LO       16
`define MBD_LAMBDA_HI     15
`define MBD_LAMBDA_LO     0
`define MBD_NIB_ONES      4'hf
`define MBD_RND_SLICE     4'h0

// Chroma sampling formats
`define MBD_FMT_MONO      2'h0
`define MBD_FMT_420       2'h1
`define MBD_FMT_422       2'h2
`define MBD_FMT_444       2'h3

// Slice types
`define MBD_SLICE_P       2'h0
`define MBD_SLICE_B       2'h1
`define MBD_SLICE_I       2'h2

// Host control port
`define MBD_A_CTRL        4'h0
`define MBD_A_STATUS      4'h1
`define MBD_A_USED        4'h2
`define MBD_A_QP          4'h3
`define MBD_A_ROUND       4'h4
`define MBD_CTRL_RST      8'h07

`endif

/* logic/mbd_budget.v */
// Accumulated size tracking against the hard and soft budgets
`timescale 1ns/1ps
`default_nettype none
`include "mbd_map.vh"

module mbd_budget (
   input  wire       mclk,
   input  wire       rst,
   input  wire       clear,
   input  wire       load,
   input  wire [7:0] hard_size_budget,
   input  wire [7:0] soft_size_budget,
   input  wire       size_valid,
   input  wire [7:0] size_words,
   output reg        panic_q,
   output reg        limit_q,
   output reg [15:0] used_q
);

   reg  [7:0]  hard_q;
   reg  [7:0]  soft_q;
   wire [15:0] sum_d = used_q + {8'h00, size_words};

   // Accumulate packer output; flags track the totals
   always @(posedge mclk) begin
      if (rst || clear) begin
         hard_q  <= 8'hff;
         soft_q  <= 8'hff;
         used_q  <= 16'h0000;
         panic_q <= 1'b0;
         limit_q <= 1'b0;
      end else begin
         if (load) begin
            hard_q <= hard_size_budget;
            soft_q <= soft_size_budget;
         end
         if (size_valid) begin
            used_q <= sum_d;
            // Panic is sticky until cleared
            if (sum_d > {8'h00, hard_q})
               panic_q <= 1'b1;
            limit_q <= (sum_d > {8'h00, soft_q});
         end
      end
   end

endmodule // mbd_budget
`default_nettype wire

/* logic/mbd_decoder.v */
// Macroblock descriptor decoder top: capture words, then decode fields
//
// Decided for this implementation: the register offsets and strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "mbd_map.vh"

module mbd_decoder (
   input  wire        mclk,
   input  wire        rst,
   input  wire        desc_valid,
   input  wire [31:0] desc_data,
   output wire        desc_ready,
   input  wire        size_valid,
   input  wire [7:0]  size_words,
   input  wire [3:0]  reg_addr,
   input  wire [31:0] reg_wdata,
   input  wire        reg_wr,
   input  wire        reg_rd,
   output reg  [31:0] reg_rdata,
   input  wire        mb_ack,
   output reg         mb_valid_q,
   output reg  [15:0] luma_coded_pattern,
   output reg  [15:0] chroma_cb_coded_pattern,
   output reg  [15:0] chroma_cr_coded_pattern,
   output reg         large_transform_select,
   output reg         intra_block_flag,
   output reg  [3:0]  sub_block_direct_mask,
   output reg         coefficient_clamp_enable,
   output reg         final_block_in_slice,
   output reg         skip_conversion_off,
   output reg  [7:0]  luma_quantizer_value,
   output reg         qp_range_error,
   output reg         trellis_active,
   output reg  [16:0] trellis_lambda,
   output reg         round_from_slice,
   output reg  [3:0]  round_sixteenths,
   output reg  [63:0] luma_intra_direction,
   output reg  [5:0]  neighbor_available_flags,
   output reg  [1:0]  chroma_intra_direction,
   output reg  [95:0] inter_words,
   output wire        panic_mode,
   output wire        coeff_limit
);

   localparam ST_FILL = 1'b0;
   localparam ST_HOLD = 1'b1;

   // Raw descriptor words, filled in order
   reg [31:0] word_q [0:10];
   reg [3:0]  idx_q;
   reg        st_q;

   // Control register: trellis enable, slice skip off, format, slice type
   reg        trellis_quant_enable;
   reg        slice_skip_conversion_off;
   reg [1:0]  chroma_format_q;
   reg [1:0]  slice_type_q;
   reg        clear_q;

   wire [15:0] used_w;
   wire        budget_load = (st_q == ST_FILL) && desc_valid && (idx_q == `MBD_W_LAST);

   // Pick a pattern nibble laid out with block X at bit 3-X
   function [3:0] nib_rev;
      input [3:0] n;
      begin
         nib_rev = {n[0], n[1], n[2], n[3]};
      end
   endfunction

   // Reverse 16 bits so block X lands at index X
   function [15:0] rev16;
      input [15:0] v;
      integer i;
      begin
         rev16 = 16'h0000;
         for (i = 0; i < 16; i = i + 1)
            rev16[i] = v[15 - i];
      end
   endfunction

   // Accept a word only while filling; holding stalls the source
   assign desc_ready = (st_q == ST_FILL);

   // Collect all words before any field is decoded
   always @(posedge mclk) begin
      if (rst) begin
         idx_q <= 4'h0;
         st_q  <= ST_FILL;
      end else begin
         case (st_q)
            ST_FILL: begin
               if (desc_valid) begin
                  if (idx_q == `MBD_W_LAST) begin
                     idx_q <= 4'h0;
                     st_q  <= ST_HOLD;
                  end else begin
                     idx_q <= idx_q + 4'h1;
                  end
               end
            end
            ST_HOLD: begin
               if (mb_ack)
                  st_q <= ST_FILL;
            end
            default: st_q <= ST_FILL;
         endcase
      end
   end

   // Word storage, no reset needed for data
   always @(posedge mclk) begin
      if ((st_q == ST_FILL) && desc_valid)
         word_q[idx_q] <= desc_data;
   end

   // Decoded fields are produced one cycle after the last word lands
   reg        dec_go_q;
   always @(posedge mclk) begin
      if (rst)
         dec_go_q <= 1'b0;
      else
         dec_go_q <= budget_load;
   end

   // Field decode from one complete descriptor
   wire [31:0] w3  = word_q[`MBD_W_MODE];
   wire [31:0] w5  = word_q[`MBD_W_CHROMA];
   wire [31:0] w6  = word_q[`MBD_W_CTRL];
   wire [31:0] w7  = word_q[`MBD_W_INTRA0];
   wire [31:0] w8  = word_q[`MBD_W_INTRA1];
   wire [31:0] w9  = word_q[`MBD_W_INTRA2];
   wire [31:0] w10 = word_q[`MBD_W_BUDGET];
   wire        is_intra = w3[`MBD_INTRA_BIT];
   wire        is_tx8   = w3[`MBD_TX8_BIT];
   wire        is_i16   = is_intra && (w3[`MBD_MBTYPE_HI:`MBD_MBTYPE_LO] != 5'h00);
   wire [15:0] lam      = w10[`MBD_LAMBDA_HI:`MBD_LAMBDA_LO];
   wire        lam_ones = (lam[15:12] == `MBD_NIB_ONES);

   always @(posedge mclk) begin
      if (rst) begin
         mb_valid_q               <= 1'b0;
         luma_coded_pattern       <= 16'h0000;
         chroma_cb_coded_pattern  <= 16'h0000;
         chroma_cr_coded_pattern  <= 16'h0000;
         large_transform_select   <= 1'b0;
         intra_block_flag         <= 1'b0;
         sub_block_direct_mask    <= 4'h0;
         coefficient_clamp_enable <= 1'b0;
         final_block_in_slice     <= 1'b0;
         skip_conversion_off      <= 1'b0;
         luma_quantizer_value     <= 8'h00;
         qp_range_error           <= 1'b0;
         trellis_active           <= 1'b0;
         trellis_lambda           <= 17'h00000;
         round_from_slice         <= 1'b0;
         round_sixteenths         <= 4'h0;
         luma_intra_direction     <= 64'h0;
         neighbor_available_flags <= 6'h00;
         chroma_intra_direction   <= 2'h0;
         inter_words              <= 96'h0;
      end else begin
         if (mb_ack)
            mb_valid_q <= 1'b0;
         if (dec_go_q) begin
            mb_valid_q             <= 1'b1;
            intra_block_flag       <= is_intra;
            large_transform_select <= is_tx8;
            // Pattern bits are presented per block index; zero means absent
            if (is_tx8 && !is_i16)
               luma_coded_pattern <= {12'h000, nib_rev(w5[3:0])};
            else
               luma_coded_pattern <= rev16(w5[15:0]);
            case (chroma_format_q)
               `MBD_FMT_MONO: begin
                  chroma_cb_coded_pattern <= 16'h0000;
                  chroma_cr_coded_pattern <= 16'h0000;
               end
               `MBD_FMT_422: begin
                  // Cb low byte and Cr bits 23:16 reversed into block order; upper half stays zero
                  chroma_cb_coded_pattern <= rev16({w5[7:0], 8'h00});
                  chroma_cr_coded_pattern <= rev16({w5[23:16], 8'h00});
               end
               `MBD_FMT_444: begin
                  chroma_cb_coded_pattern <= rev16(w5[`MBD_CB16_HI:`MBD_CB16_LO]);
                  chroma_cr_coded_pattern <= rev16(w5[15:0]);
               end
               default: begin
                  chroma_cb_coded_pattern <= {12'h000,
                     nib_rev(w5[`MBD_CB_HI:`MBD_CB_LO])};
                  chroma_cr_coded_pattern <= {12'h000,
                     nib_rev(w5[`MBD_CR_HI:`MBD_CR_LO])};
               end
            endcase
            // Direct mask only means something for B inter blocks
            if ((slice_type_q == `MBD_SLICE_B) && !is_intra)
               sub_block_direct_mask <= w6[`MBD_DIRECT_HI:`MBD_DIRECT_LO];
            else
               sub_block_direct_mask <= 4'h0;
            coefficient_clamp_enable <= w6[`MBD_CLAMP_BIT];
            final_block_in_slice     <= w6[`MBD_LASTMB_BIT];
            // Writer keeps bit 25 clear in I slices, so no gating here
            skip_conversion_off <= w6[`MBD_SKIPOFF_BIT]
                                   | slice_skip_conversion_off;
            // Bits 23:8 deliberately unread: chroma QP is derived downstream
            luma_quantizer_value <= w6[`MBD_QP_HI:`MBD_QP_LO];
            qp_range_error       <= (w6[`MBD_QP_HI:`MBD_QP_LO] > `MBD_QP_MAX);
            trellis_active   <= trellis_quant_enable && !lam_ones;
            trellis_lambda   <= {lam, 1'b0};
            round_from_slice <= (lam[3:0] == `MBD_RND_SLICE);
            // 1000b..1111b map to 1..8 sixteenths; others give none
            round_sixteenths <= lam[3] ? ({1'b0, lam[2:0]} + 4'h1) : 4'h0;
            if (is_intra) begin
               // 16x16 intra keeps only the low two bits of mode 0
               if (is_i16)
                  luma_intra_direction <= {62'h0, w7[1:0]};
               else
                  luma_intra_direction <= {w8, w7};
               neighbor_available_flags <= w9[7:2];
               chroma_intra_direction   <= w9[1:0];
               inter_words              <= 96'h0;
            end else begin
               luma_intra_direction     <= 64'h0;
               neighbor_available_flags <= 6'h00;
               chroma_intra_direction   <= 2'h0;
               inter_words              <= {w9, w8, w7};
            end
         end
      end
   end

   // Host control port writes
   always @(posedge mclk) begin
      if (rst) begin
         trellis_quant_enable      <= 1'b0;
         slice_skip_conversion_off <= 1'b0;
         chroma_format_q           <= `MBD_FMT_420;
         slice_type_q              <= `MBD_SLICE_P;
         clear_q                   <= 1'b0;
      end else begin
         clear_q <= 1'b0;
         if (reg_wr && (reg_addr == `MBD_A_CTRL)) begin
            trellis_quant_enable      <= reg_wdata[0];
            slice_skip_conversion_off <= reg_wdata[1];
            chroma_format_q           <= reg_wdata[3:2];
            slice_type_q              <= reg_wdata[5:4];
            clear_q                   <= reg_wdata[8];
         end
      end
   end

   // Read data one cycle after the strobe; unmapped reads as zero
   always @(posedge mclk) begin
      if (rst)
         reg_rdata <= 32'h0;
      else if (reg_rd) begin
         case (reg_addr)
            `MBD_A_CTRL:   reg_rdata <= {26'h0, slice_type_q, chroma_format_q,
                                         slice_skip_conversion_off, trellis_quant_enable};
            `MBD_A_STATUS: reg_rdata <= {27'h0, coeff_limit, panic_mode, qp_range_error,
                                         st_q, mb_valid_q};
            `MBD_A_USED:   reg_rdata <= {16'h0, used_w};
            `MBD_A_QP:     reg_rdata <= {24'h0, luma_quantizer_value};
            `MBD_A_ROUND:  reg_rdata <= {27'h0, round_from_slice, round_sixteenths};
            default:       reg_rdata <= 32'h0;
         endcase
      end else
         reg_rdata <= 32'h0;
   end

   mbd_budget u_budget (
      .mclk             (mclk),
      .rst              (rst),
      .clear            (clear_q),
      .load             (budget_load),
      .hard_size_budget (desc_data[`MBD_HARD_HI:`MBD_HARD_LO]),
      .soft_size_budget (desc_data[`MBD_SOFT_HI:`MBD_SOFT_LO]),
      .size_valid       (size_valid),
      .size_words       (size_words),
      .panic_q          (panic_mode),
      .limit_q          (coeff_limit),
      .used_q           (used_w)
   );

endmodule // mbd_decoder
`default_nettype wire

/* verif/mbd_decoder_props.sv */
// Port-level checker for the macroblock descriptor decoder
`timescale 1ns/1ps
`default_nettype none
module mbd_decoder_props (
   input wire logic        mclk,
   input wire logic        rst,
   input wire logic        desc_valid,
   input wire logic        desc_ready,
   input wire logic        mb_ack,
   input wire logic        mb_valid_q,
   input wire logic [15:0] luma_coded_pattern,
   input wire logic        intra_block_flag,
   input wire logic [3:0]  sub_block_direct_mask,
   input wire logic [7:0]  luma_quantizer_value,
   input wire logic        qp_range_error,
   input wire logic        trellis_active,
   input wire logic [16:0] trellis_lambda,
   input wire logic        round_from_slice,
   input wire logic [3:0]  round_sixteenths,
   input wire logic [63:0] luma_intra_direction,
   input wire logic [95:0] inter_words
);
   logic [3:0] wcnt_q;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   // Index of the next word; lets the last word be spotted from the ports
   always @(posedge mclk) begin
      if (rst)
         wcnt_q <= 4'h0;
      else if (desc_valid && desc_ready)
         wcnt_q <= (wcnt_q == 4'ha) ? 4'h0 : wcnt_q + 4'h1;
   end
   sequence s_last_taken;
      desc_valid && desc_ready && wcnt_q == 4'ha;
   endsequence
   sequence s_answer;
      !desc_ready && !mb_valid_q ##1 mb_valid_q && !desc_ready;
   endsequence
   a_capture_answer: assert property (s_last_taken |=> s_answer)
      else $error("decoded block not presented two cycles after last word");
   a_hold_fields: assert property (mb_valid_q && !mb_ack |=> mb_valid_q
      && $stable(luma_coded_pattern) && $stable(inter_words))
      else $error("decoded fields moved while held");
   a_release_ack: assert property (mb_valid_q && mb_ack |=> !mb_valid_q && desc_ready)
      else $error("release did not follow acknowledge");
   a_busy_refuse: assert property (mb_valid_q |-> !desc_ready)
      else $error("new words accepted while block held");
   a_direct_intra: assert property (mb_valid_q && intra_block_flag |->
      sub_block_direct_mask == 4'h0) else $error("direct mask set for intra block");
   a_layout_split: assert property (mb_valid_q |-> (intra_block_flag ?
      inter_words == 96'h0 : luma_intra_direction == 64'h0))
      else $error("intra and inter layouts both decoded");
   a_qp_range: assert property (mb_valid_q |->
      qp_range_error == (luma_quantizer_value > 8'h33)) else $error("quantizer range flag wrong");
   a_trellis_bypass: assert property (trellis_active |-> trellis_lambda[16:13] != 4'hf)
      else $error("trellis active with all-ones upper nibble");
   a_round_code: assert property (mb_valid_q && trellis_lambda[4] |-> !round_from_slice
      && round_sixteenths == {1'b0, trellis_lambda[3:1]} + 4'h1)
      else $error("rounding offset code wrong");
   a_lambda_even: assert property (trellis_lambda[0] == 1'b0)
      else $error("lambda not doubled");
endmodule // mbd_decoder_props
`default_nettype wire

/* verif/mbd_cmd_src.sv */
// Command source model streaming one eleven-word descriptor
`timescale 1ns/1ps
`default_nettype none
module mbd_cmd_src (
   input  wire logic              mclk,
   input  wire logic              rst,
   input  wire logic              start,
   input  wire logic              slow,
   input  wire logic [10:0][31:0] pack,
   input  wire logic              desc_ready,
   output var  logic              desc_valid,
   output var  logic [31:0]       desc_data
);
   logic [3:0] idx;
   logic       busy;
   // Word held until taken; an idle bus shows the inverse, never the old word
   always @(posedge mclk) begin
      if (rst) begin
         desc_valid <= 1'b0;
         desc_data  <= 32'h0;
         busy       <= 1'b0;
         idx        <= 4'h0;
      end else if (desc_valid && desc_ready) begin
         idx        <= idx + 4'h1;
         busy       <= idx != 4'ha;
         desc_valid <= !slow && idx != 4'ha;
         desc_data  <= (!slow && idx != 4'ha) ? pack[idx + 4'h1] : ~desc_data;
      end else if (busy && !desc_valid) begin
         desc_valid <= 1'b1;
         desc_data  <= pack[idx];
      end else if (start && !busy) begin
         busy <= 1'b1;
         idx  <= 4'h0;
      end
   end
endmodule // mbd_cmd_src
`default_nettype wire

/* verif/tb_mbd_decoder.sv */
// Testbench for the macroblock descriptor decoder
`timescale 1ns/1ps
`default_nettype none
module tb_mbd_decoder;
   logic mclk, rst, desc_valid, desc_ready, size_valid, reg_wr, reg_rd, mb_ack;
   logic mb_valid_q, large_transform_select, intra_block_flag, coefficient_clamp_enable;
   logic final_block_in_slice, skip_conversion_off, qp_range_error, trellis_active;
   logic round_from_slice, panic_mode, coeff_limit, start, slow;
   logic [31:0] desc_data, reg_wdata, reg_rdata, rd_val;
   logic [15:0] luma_coded_pattern, chroma_cb_coded_pattern, chroma_cr_coded_pattern;
   logic [7:0]  size_words, luma_quantizer_value;
   logic [3:0]  reg_addr, sub_block_direct_mask, round_sixteenths;
   logic [16:0] trellis_lambda;
   logic [63:0] luma_intra_direction;
   logic [5:0]  neighbor_available_flags;
   logic [1:0]  chroma_intra_direction;
   logic [95:0] inter_words;
   logic [10:0][31:0] pack;
   int err_total, cmp_count, cyc;

   mbd_decoder i_mbd_decoder (.*);
   mbd_cmd_src i_mbd_cmd_src (.*);

   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   // Hang guard: a run should need well under this many cycles
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         err_total++;
         tally_and_finish;
      end
   end

   function automatic logic [15:0] rev(input logic [15:0] v, input int n);
      rev = 16'h0;
      for (int i = 0; i < n; i++)
         rev[i] = v[n-1-i];
   endfunction

   task automatic chk(input string nm, input logic [95:0] seen, input logic [95:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected %s: expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge mclk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask

   // Read data stands only in the cycle after the strobe
   task automatic rd(input logic [3:0] a);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1 rd_val = reg_rdata;
   endtask

   task automatic kick(input logic s);
      @(posedge mclk);
      slow  <= s;
      start <= 1'b1;
      @(posedge mclk);
      start <= 1'b0;
   endtask

   task automatic await_mb;
      int n;
      n = 0;
      while (mb_valid_q !== 1'b1 && n < 60) begin
         @(posedge mclk);
         #1 n++;
      end
      chk("mb_valid_q", mb_valid_q, 1'b1);
   endtask

   task automatic ack;
      @(posedge mclk);
      mb_ack <= 1'b1;
      @(posedge mclk);
      mb_ack <= 1'b0;
      #1 chk("release", {mb_valid_q, desc_ready}, 2'b01);
   endtask

   task automatic grow(input logic [7:0] n, input logic [1:0] e);
      @(posedge mclk);
      size_valid <= 1'b1;
      size_words <= n;
      @(posedge mclk);
      size_valid <= 1'b0;
      @(posedge mclk);
      #1 chk("budget", {coeff_limit, panic_mode}, e);
   endtask

   task automatic tally_and_finish;
      $display("compares %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   initial begin
      {rst, start, slow, size_valid, reg_wr, reg_rd, mb_ack} = 7'h40;
      {size_words, reg_addr, reg_wdata} = '0;
      pack = '0;
      {err_total, cmp_count, cyc} = '0;
      repeat (8) @(posedge mclk);
      rst <= 1'b0;
      // B slice inter block, slow words, then budgets
      wr(4'h0, 32'h15);
      pack = {32'h1004_1238, 32'h9999_9999, 32'h8888_8888, 32'h0000_7777,
              32'ha800_0033, 32'h00a3_c001, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
      kick(1'b1);
      await_mb;
      chk("luma", luma_coded_pattern, rev(16'hc001, 16));
      chk("cr", chroma_cr_coded_pattern[3:0], rev(16'ha, 4));
      chk("cb", chroma_cb_coded_pattern[3:0], rev(16'h3, 4));
      chk("ctl", {large_transform_select, intra_block_flag, sub_block_direct_mask,
         coefficient_clamp_enable, final_block_in_slice, skip_conversion_off},
         {2'b00, 4'ha, 3'b100});
      chk("qp", {qp_range_error, luma_quantizer_value}, 9'h033);
      chk("tq", {trellis_active, trellis_lambda}, {1'b1, 17'h02470});
      chk("rnd", {round_from_slice, round_sixteenths}, 5'h01);
      chk("inter", inter_words, {32'h9999_9999, 32'h8888_8888, 32'h0000_7777});
      chk("ldir", luma_intra_direction, 64'h0);
      grow(8'h03, 2'b00);
      grow(8'h02, 2'b10);
      grow(8'h0b, 2'b10);
      grow(8'h01, 2'b11);
      rd(4'h2);
      chk("used", rd_val, 32'h11);
      rd(4'hf);
      chk("hole", rd_val, 32'h0);
      wr(4'h0, 32'h115);
      rd(4'h2);
      chk("cleared", rd_val, 32'h0);
      ack;
      $display("test inter done");
      // P slice intra 8x8, words back to back
      wr(4'h0, 32'h07);
      pack = {32'h0000_f00b, 32'h0000_00b6, 32'hfedc_ba98, 32'h8765_4321,
              32'h56ab_cd34, 32'h0000_fff4, 32'h0, 32'h0000_a000, 32'h0, 32'h0, 32'h0};
      kick(1'b0);
      await_mb;
      chk("luma8", luma_coded_pattern[3:0], rev(16'h4, 4));
      chk("ctl", {large_transform_select, intra_block_flag, sub_block_direct_mask,
         coefficient_clamp_enable, final_block_in_slice, skip_conversion_off},
         {2'b11, 4'h0, 3'b011});
      chk("qp", {qp_range_error, luma_quantizer_value}, 9'h134);
      chk("tq", trellis_active, 1'b0);
      chk("rnd", {round_from_slice, round_sixteenths}, 5'h04);
      chk("ldir", luma_intra_direction, 64'hfedc_ba98_8765_4321);
      chk("nbr", {neighbor_available_flags, chroma_intra_direction}, 8'hb6);
      chk("inter", inter_words, 96'h0);
      rd(4'h3);
      chk("qp_reg", rd_val, 32'h34);
      rd(4'h4);
      chk("round_reg", rd_val, 32'h04);
      rd(4'h1);
      chk("status", rd_val, 32'h7);
      // Next descriptor offered while this one is held; skip-off bit zero in I slice
      pack = {32'h0, 32'h0000_0003, 32'h0, 32'h0000_0007, 32'h0400_0000,
              32'hff81_5ac4, 32'h0, 32'h0000_2100, 32'h0, 32'h0, 32'h0};
      wr(4'h0, 32'h29);
      kick(1'b0);
      repeat (4) @(posedge mclk);
      #1 chk("hold", {desc_ready, luma_coded_pattern[3:0]}, 5'h02);
      ack;
      $display("test intra done");
      // I slice 16x16 intra in 4:2:2
      await_mb;
      chk("luma", luma_coded_pattern, rev(16'h5ac4, 16));
      chk("cb", chroma_cb_coded_pattern[7:0], rev(16'hc4, 8));
      chk("ctl", {large_transform_select, intra_block_flag, sub_block_direct_mask,
         coefficient_clamp_enable, final_block_in_slice, skip_conversion_off},
         {2'b01, 4'h0, 3'b010});
      chk("qp", {qp_range_error, luma_quantizer_value}, 9'h000);
      chk("tq", {trellis_active, trellis_lambda, round_from_slice, round_sixteenths},
         {1'b1, 17'h0, 1'b1, 4'h0});
      chk("ldir", luma_intra_direction, 64'h3);
      chk("nbr", {neighbor_available_flags, chroma_intra_direction}, 8'h03);
      ack;
      $display("test large intra done");
      tally_and_finish;
   end
endmodule // tb_mbd_decoder

bind mbd_decoder mbd_decoder_props i_mbd_decoder_props (.mclk, .rst, .desc_valid,
   .desc_ready, .mb_ack, .mb_valid_q, .luma_coded_pattern, .intra_block_flag,
   .sub_block_direct_mask, .luma_quantizer_value, .qp_range_error, .trellis_active,
   .trellis_lambda, .round_from_slice, .round_sixteenths, .luma_intra_direction,
   .inter_words);
`default_nettype wire
